// File: logic/lfc_regs.sv
// What this block does
// R01: squelch bit mutes both audio sense inputs
// R02: bit 5 bypasses both filter capacitors
// R03: bit 4 enables external transistor bias
// R04: bits 3:2 pick on-hook bias current
// R05: bits 1:0 pick off-hook bias current
// R06: bit 4 selects overhead voltage range
// R07: bit 3 forces battery to high setting
// R08: bit 0 makes battery track ring leg
// R09: bit 6 makes common mode manual
// R10: bit 5 makes differential control manual
// R11: bit 4 enables automatic speed-up
// R12: ring trip auto-enters forward active when enabled
// R13: loop closure auto-enters forward active when enabled
// R14: power alarm auto-opens line when enabled
// R15: status bit 2 shows raw detector, inverted
// R16: status bit 1 shows debounced ring trip
// R17: status bit 0 shows debounced loop closure
// R18: seven-bit debounce time in 1.25 ms steps
// R19: auto changes act on line state shadow
// R20: loop flag changes after steady programmed interval
`timescale 1ns/1ps
`default_nettype none
module lfc_regs #(
    parameter int TICK_LEN = lfc_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire  logic                       REF_CLK_I,
    input  wire  logic                       RSTN_I,
    // axi4-lite write address and data
    input  wire  logic                       S_AXI_AWVALID_I,
    output logic                             S_AXI_AWREADY_O,
    input  wire  logic [lfc_pkg::ADDR_W-1:0] S_AXI_AWADDR_I,
    input  wire  logic [2:0]                 S_AXI_AWPROT_I,
    input  wire  logic                       S_AXI_WVALID_I,
    output logic                             S_AXI_WREADY_O,
    input  wire  logic [31:0]                S_AXI_WDATA_I,
    input  wire  logic [3:0]                 S_AXI_WSTRB_I,
    // axi4-lite write response
    output logic                             S_AXI_BVALID_O,
    input  wire  logic                       S_AXI_BREADY_I,
    output logic [1:0]                       S_AXI_BRESP_O,
    // axi4-lite read
    input  wire  logic                       S_AXI_ARVALID_I,
    output logic                             S_AXI_ARREADY_O,
    input  wire  logic [lfc_pkg::ADDR_W-1:0] S_AXI_ARADDR_I,
    input  wire  logic [2:0]                 S_AXI_ARPROT_I,
    output logic                             S_AXI_RVALID_O,
    input  wire  logic                       S_AXI_RREADY_I,
    output logic [31:0]                      S_AXI_RDATA_O,
    output logic [1:0]                       S_AXI_RRESP_O,
    // line side
    input  wire  logic                       DETECT_HIT_I,
    input  wire  logic                       POWER_ALARM_I,
    output lfc_pkg::lfc_ctrl_t               CTRL_O
);
    import lfc_pkg::*;

    logic [7:0]  xbias_reg, xbias_next;
    logic [7:0]  batt_reg, batt_next;
    logic [7:0]  auto_reg, auto_next;
    logic [7:0]  lcdeb_reg, lcdeb_next;
    logic [2:0]  sel_reg, sel_next;
    lfc_state_t  shadow_reg, shadow_next;
    logic        aw_full_reg, aw_full_next;
    logic        w_full_reg, w_full_next;
    logic [7:0]  aw_idx_reg, aw_idx_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0]  wstrb_reg, wstrb_next;
    logic        bvalid_reg, bvalid_next;
    logic [1:0]  bresp_reg, bresp_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  rresp_reg, rresp_next;
    logic [18:0] tick_cnt_reg, tick_cnt_next;
    logic        tick;
    logic [1:0]  flag_reg, flag_next;
    logic [6:0]  dbc_reg [2];
    logic [6:0]  dbc_next [2];
    logic [1:0]  det_in;
    logic [6:0]  dbc_len [2];
    logic        wr_fire;
    logic        rt_rise, lc_rise;
    logic [7:0]  wr_idx;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;

    // ready while the holding slot is free and no response is pending
    assign S_AXI_AWREADY_O = !aw_full_reg && !bvalid_reg;
    assign S_AXI_WREADY_O  = !w_full_reg && !bvalid_reg;
    assign S_AXI_ARREADY_O = !rvalid_reg;
    assign S_AXI_BVALID_O  = bvalid_reg;
    assign S_AXI_BRESP_O   = bresp_reg;
    assign S_AXI_RVALID_O  = rvalid_reg;
    assign S_AXI_RDATA_O   = rdata_reg;
    assign S_AXI_RRESP_O   = rresp_reg;

    // address and data may come in either order; the write fires once both are held
    always_comb begin
        aw_full_next = aw_full_reg;
        w_full_next  = w_full_reg;
        aw_idx_next  = aw_idx_reg;
        wdata_next   = wdata_reg;
        wstrb_next   = wstrb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
            aw_full_next = 1'b1;
            aw_idx_next  = lfc_index(S_AXI_AWADDR_I);
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
            w_full_next = 1'b1;
            wdata_next  = S_AXI_WDATA_I;
            wstrb_next  = S_AXI_WSTRB_I;
        end
        wr_fire = aw_full_reg && w_full_reg;
        wr_idx  = aw_idx_reg;
        wr_data = wdata_reg;
        wr_strb = wstrb_reg;
        if (wr_fire) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = (wr_idx >= LINE_STATE_IDX && wr_idx <= LCDEB_IDX)
                           ? RESP_OKAY : RESP_SLVERR;
        end
        if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_next = 1'b0;
        end
    end

    // read data is captured at the address handshake, so status is a snapshot
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_next = 1'b0;
        end
        if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
            rvalid_next = 1'b1;
            rresp_next  = RESP_OKAY;
            rdata_next  = 32'h0000_0000;
            unique case (lfc_index(S_AXI_ARADDR_I))
                LINE_STATE_IDX: rdata_next[6:0] = {shadow_reg, 1'b0, sel_reg};
                XBIAS_IDX:      rdata_next[7:0] = xbias_reg;
                BATT_IDX:       rdata_next[7:0] = batt_reg;
                AUTO_IDX:       rdata_next[7:0] = auto_reg;
                STATUS_IDX: begin
                    rdata_next[STAT_RAW_B] = !DETECT_HIT_I; // [R15]
                    rdata_next[STAT_RT_B]  = flag_reg[1];   // [R16]
                    rdata_next[STAT_LC_B]  = flag_reg[0];   // [R17]
                end
                LCDEB_IDX:      rdata_next[7:0] = lcdeb_reg;
                default:        rresp_next = RESP_SLVERR;
            endcase
        end
    end

    // software-written control bytes; only the low lane carries register bits
    always_comb begin
        xbias_next = xbias_reg;
        batt_next  = batt_reg;
        auto_next  = auto_reg;
        lcdeb_next = lcdeb_reg;
        sel_next   = sel_reg;
        if (wr_fire && wr_strb[0]) begin
            unique case (wr_idx)
                XBIAS_IDX: xbias_next = wr_data[7:0] & XBIAS_MASK; // [R01] [R02] [R03]
                BATT_IDX:  batt_next  = wr_data[7:0] & BATT_MASK;  // [R06] [R07] [R08]
                AUTO_IDX:  auto_next  = wr_data[7:0] & AUTO_MASK;  // [R09] [R10] [R11]
                LCDEB_IDX: lcdeb_next = wr_data[7:0] & LCDEB_MASK; // [R18]
                LINE_STATE_IDX: sel_next = wr_data[2:0];
                default: ;
            endcase
        end
    end

    // free-running 1.25 ms tick; the length is a parameter so simulation can shorten it
    always_comb begin
        tick          = (tick_cnt_reg == 19'(TICK_LEN - 1));
        tick_cnt_next = tick ? 19'h0_0000 : tick_cnt_reg + 19'h0_0001;
    end

    // the one detector means ring trip while ringing and loop closure otherwise
    assign det_in[0]  = DETECT_HIT_I && (shadow_reg != LS_RINGING);
    assign det_in[1]  = DETECT_HIT_I && (shadow_reg == LS_RINGING);
    assign dbc_len[0] = lcdeb_reg[6:0];
    assign dbc_len[1] = RTDEB_TICK;

    // a flag follows its input only after the new level held for the whole interval;
    // any bounce restarts the count, so the interval is a minimum steady time
    // the first tick of a count is partial, so the change waits for the tick after it
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            flag_next[i] = flag_reg[i];
            dbc_next[i]  = dbc_reg[i];
            if (det_in[i] == flag_reg[i]) begin
                dbc_next[i] = 7'h00;
            end else if (tick && dbc_reg[i] >= dbc_len[i]) begin
                flag_next[i] = det_in[i]; // [R20] [R16] [R17]
                dbc_next[i]  = 7'h00;
            end else if (tick) begin
                dbc_next[i] = dbc_reg[i] + 7'h01; // [R18]
            end
        end
    end

    // alarm wins over the off-hook entries, a software write loses to all of them
    always_comb begin
        rt_rise     = flag_next[1] && !flag_reg[1];
        lc_rise     = flag_next[0] && !flag_reg[0];
        shadow_next = shadow_reg;
        if (wr_fire && wr_strb[0] && wr_idx == LINE_STATE_IDX) begin
            shadow_next = lfc_state_t'(wr_data[2:0]);
        end
        if (rt_rise && auto_reg[AUTO_RT_B]) begin
            shadow_next = LS_FWD_ACT; // [R12] [R19]
        end
        if (lc_rise && auto_reg[AUTO_LC_B]) begin
            shadow_next = LS_FWD_ACT; // [R13] [R19]
        end
        if (POWER_ALARM_I && auto_reg[AUTO_OPEN_B]) begin
            shadow_next = LS_OPEN; // [R14] [R19]
        end
    end

    // state registers
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            xbias_reg    <= XBIAS_RST;
            batt_reg     <= BATT_RST;
            auto_reg     <= AUTO_RST;
            lcdeb_reg    <= LCDEB_RST;
            sel_reg      <= 3'h0;
            shadow_reg   <= LS_OPEN;
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            aw_idx_reg   <= 8'h00;
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= 2'h0;
            rvalid_reg   <= 1'b0;
            rdata_reg    <= 32'h0000_0000;
            rresp_reg    <= 2'h0;
            tick_cnt_reg <= 19'h0_0000;
            flag_reg     <= 2'h0;
            dbc_reg[0]   <= 7'h00;
            dbc_reg[1]   <= 7'h00;
        end else begin
            xbias_reg    <= xbias_next;
            batt_reg     <= batt_next;
            auto_reg     <= auto_next;
            lcdeb_reg    <= lcdeb_next;
            sel_reg      <= sel_next;
            shadow_reg   <= shadow_next;
            aw_full_reg  <= aw_full_next;
            w_full_reg   <= w_full_next;
            aw_idx_reg   <= aw_idx_next;
            wdata_reg    <= wdata_next;
            wstrb_reg    <= wstrb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rdata_reg    <= rdata_next;
            rresp_reg    <= rresp_next;
            tick_cnt_reg <= tick_cnt_next;
            flag_reg     <= flag_next;
            dbc_reg[0]   <= dbc_next[0];
            dbc_reg[1]   <= dbc_next[1];
        end
    end

    // control bundle; bias level follows the on-hook or off-hook field by line state
    always_comb begin
        CTRL_O.audio_mute          = xbias_reg[AUDIO_MUTE_B]; // [R01]
        CTRL_O.cap_bypass          = xbias_reg[CAP_BYPASS_B]; // [R02]
        CTRL_O.bias_enable         = xbias_reg[BIAS_EN_B];    // [R03]
        CTRL_O.overhead_range_sel  = batt_reg[OVH_RANGE_B];   // [R06]
        CTRL_O.battery_force_high  = batt_reg[BATT_HIGH_B];   // [R07]
        CTRL_O.track_ring          = batt_reg[TRACK_B];       // [R08]
        CTRL_O.common_manual       = auto_reg[COMMON_MAN_B];  // [R09]
        CTRL_O.differential_manual = auto_reg[DIFF_MAN_B];    // [R10]
        CTRL_O.speedup_enable      = auto_reg[SPEEDUP_B];     // [R11]
        CTRL_O.line_state_shadow   = shadow_reg;              // [R19]
        unique case (shadow_reg)
            LS_FWD_OHT, LS_REV_OHT:
                CTRL_O.bias_level = xbias_reg[BIAS_ON_LSB +: 2];  // [R04]
            LS_OPEN, LS_FWD_ACT, LS_TIP_OPEN, LS_RINGING, LS_REV_ACT, LS_RING_OPN:
                CTRL_O.bias_level = xbias_reg[BIAS_OFF_LSB +: 2]; // [R05]
        endcase
    end

    // checks
    sequence s_wr_xbias;
        wr_fire && wr_strb[0] && wr_idx == XBIAS_IDX;
    endsequence

    a_alarm_opens: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R14]
        POWER_ALARM_I && auto_reg[AUTO_OPEN_B] |=> shadow_reg == LS_OPEN)
        else $error("power alarm did not open the line");
    a_ringtrip_act: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R12]
        $rose(flag_reg[1]) && $past(auto_reg[AUTO_RT_B]) && !$past(POWER_ALARM_I)
        |-> shadow_reg == LS_FWD_ACT)
        else $error("ring trip did not enter forward active");
    a_loop_act: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R13]
        $rose(flag_reg[0]) && $past(auto_reg[AUTO_LC_B]) && !$past(POWER_ALARM_I)
        |-> shadow_reg == LS_FWD_ACT)
        else $error("loop closure did not enter forward active");
    a_loop_steady: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R20]
        $changed(flag_reg[0]) |-> $past(det_in[0]) == flag_reg[0]
        && $past(dbc_reg[0]) >= $past(lcdeb_reg[6:0]))
        else $error("loop flag changed before the interval");
    a_onhook_bias: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R04]
        shadow_reg == LS_FWD_OHT |-> CTRL_O.bias_level == xbias_reg[3:2])
        else $error("on-hook bias level not selected");
    a_offhook_bias: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R05]
        shadow_reg == LS_FWD_ACT |-> CTRL_O.bias_level == xbias_reg[1:0])
        else $error("off-hook bias level not selected");
    a_bias_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R03]
        s_wr_xbias |=> CTRL_O.bias_enable == $past(wr_data[4])
        && CTRL_O.audio_mute == $past(wr_data[6]))
        else $error("bias control write not applied");
    a_raw_status: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R15]
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && lfc_index(S_AXI_ARADDR_I) == STATUS_IDX
        |=> S_AXI_RVALID_O && S_AXI_RDATA_O[2] == !$past(DETECT_HIT_I))
        else $error("raw detector status wrong");
    a_debounce_tick: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R18]
        dbc_reg[0] != $past(dbc_reg[0]) && dbc_reg[0] != 7'h00 |-> $past(tick))
        else $error("debounce counted without a tick");

    // writes to the feed control bytes reach the bundle one edge later
    sequence s_wr_batt;
        wr_fire && wr_strb[0] && wr_idx == BATT_IDX;
    endsequence

    sequence s_wr_auto;
        wr_fire && wr_strb[0] && wr_idx == AUTO_IDX;
    endsequence

    sequence s_rd_status;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O && lfc_index(S_AXI_ARADDR_I) == STATUS_IDX;
    endsequence

    a_cap_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R02]
        s_wr_xbias |=> CTRL_O.cap_bypass == $past(wr_data[5]))
        else $error("capacitor bypass write not applied");
    a_batt_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R06] [R07] [R08]
        s_wr_batt |=> CTRL_O.overhead_range_sel == $past(wr_data[4])
        && CTRL_O.battery_force_high == $past(wr_data[3])
        && CTRL_O.track_ring == $past(wr_data[0]))
        else $error("battery feed write not applied");
    a_auto_write: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R09] [R10] [R11]
        s_wr_auto |=> CTRL_O.common_manual == $past(wr_data[6])
        && CTRL_O.differential_manual == $past(wr_data[5])
        && CTRL_O.speedup_enable == $past(wr_data[4]))
        else $error("auto/manual write not applied");

    // debounced flags: reported as held, and moved only on a tick
    a_status_flags: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R16] [R17]
        s_rd_status |=> S_AXI_RDATA_O[1:0] == $past(flag_reg))
        else $error("debounced flags not reported");
    a_ringtrip_src: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R16]
        $rose(flag_reg[1]) |-> $past(shadow_reg) == LS_RINGING)
        else $error("ring trip flag rose outside ringing");
    a_flag_on_tick: assert property (@(posedge REF_CLK_I) disable iff (!RSTN_I) // [R20]
        $changed(flag_reg[0]) |-> $past(tick))
        else $error("loop flag moved between ticks");
endmodule
`default_nettype wire

// File: logic/lfc_pkg.sv
`default_nettype none
package lfc_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] LINE_STATE_IDX = 8'h40;
    localparam logic [7:0] XBIAS_IDX      = 8'h41;
    localparam logic [7:0] BATT_IDX       = 8'h42;
    localparam logic [7:0] AUTO_IDX       = 8'h43;
    localparam logic [7:0] STATUS_IDX     = 8'h44;
    localparam logic [7:0] LCDEB_IDX      = 8'h45;
    localparam int         ADDR_W         = 12;

    // reset values
    localparam logic [7:0] XBIAS_RST  = 8'h00;
    localparam logic [7:0] BATT_RST   = 8'h03;
    localparam logic [7:0] AUTO_RST   = 8'h00;
    localparam logic [7:0] LCDEB_RST  = 8'h0a;
    localparam logic [6:0] RTDEB_TICK = 7'h0a;

    // writable bits of each register; reserved bits read as zero once written, but BATT_RST sets bit 1
    localparam logic [7:0] XBIAS_MASK = 8'h7f;
    localparam logic [7:0] BATT_MASK  = 8'h19;
    localparam logic [7:0] AUTO_MASK  = 8'h77;
    localparam logic [7:0] LCDEB_MASK = 8'h7f;

    // field positions
    localparam int AUDIO_MUTE_B  = 6;
    localparam int CAP_BYPASS_B  = 5;
    localparam int BIAS_EN_B     = 4;
    localparam int BIAS_ON_LSB   = 2;
    localparam int BIAS_OFF_LSB  = 0;
    localparam int OVH_RANGE_B   = 4;
    localparam int BATT_HIGH_B   = 3;
    localparam int TRACK_B       = 0;
    localparam int COMMON_MAN_B  = 6;
    localparam int DIFF_MAN_B    = 5;
    localparam int SPEEDUP_B     = 4;
    localparam int AUTO_RT_B     = 2;
    localparam int AUTO_LC_B     = 1;
    localparam int AUTO_OPEN_B   = 0;
    localparam int STAT_RAW_B    = 2;
    localparam int STAT_RT_B     = 1;
    localparam int STAT_LC_B     = 0;
    localparam int SHADOW_LSB    = 4;

    // debounce tick: 1.25 ms at a 4 ns clock
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_NS       = 1250000;
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        LS_OPEN     = 3'b000,
        LS_FWD_ACT  = 3'b001,
        LS_FWD_OHT  = 3'b010,
        LS_TIP_OPEN = 3'b011,
        LS_RINGING  = 3'b100,
        LS_REV_ACT  = 3'b101,
        LS_REV_OHT  = 3'b110,
        LS_RING_OPN = 3'b111
    } lfc_state_t;

    // control bundle driven to the analog feed circuits
    typedef struct packed {
        logic       audio_mute;
        logic       cap_bypass;
        logic       bias_enable;
        logic [1:0] bias_level;
        logic       overhead_range_sel;
        logic       battery_force_high;
        logic       track_ring;
        logic       common_manual;
        logic       differential_manual;
        logic       speedup_enable;
        logic [2:0] line_state_shadow;
    } lfc_ctrl_t;

    function automatic logic [7:0] lfc_index(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction
endpackage
`default_nettype wire

// File: testbench/line_feed_control_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module line_feed_control_registers_tb;
    import lfc_pkg::*;
    localparam int TICK = 4;
    logic        clk, rstn, det, alarm;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    lfc_ctrl_t   ctrl;
    int          n_mismatch;
    int          total_checks;

    // short tick keeps debounce runs to tens of cycles
    lfc_regs #(.TICK_LEN(TICK)) lfc_regs_inst (
        .REF_CLK_I(clk), .RSTN_I(rstn),
        .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
        .S_AXI_AWPROT_I(3'h0), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bvalid),
        .S_AXI_BREADY_I(bready), .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARPROT_I(3'h0),
        .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .DETECT_HIT_I(det), .POWER_ALARM_I(alarm), .CTRL_O(ctrl));

    // 250 MHz bench clock
    always #2 clk = ~clk;

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // expected feed controls, worked out from the field layout
    function automatic lfc_ctrl_t exp_ctrl(input logic [7:0] xb, input logic [7:0] bt,
                                           input logic [7:0] au, input logic [2:0] sh);
        lfc_ctrl_t e;
        e.audio_mute          = xb[6];
        e.cap_bypass          = xb[5];
        e.bias_enable         = xb[4];
        e.bias_level          = (sh == 3'b010 || sh == 3'b110) ? xb[3:2] : xb[1:0];
        e.overhead_range_sel  = bt[4];
        e.battery_force_high  = bt[3];
        e.track_ring          = bt[0];
        e.common_manual       = au[6];
        e.differential_manual = au[5];
        e.speedup_enable      = au[4];
        e.line_state_shadow   = sh;
        return e;
    endfunction

    // each task is entered just after an edge and leaves one edge after release,
    // so no handshake signal is assigned twice in a time step
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awvalid <= 1'b1;
        awaddr  <= {2'b00, idx, 2'b00};
        wvalid  <= 1'b1;
        wdata   <= {24'h0, d};
        wstrb   <= s;
        bready  <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1;
        araddr  <= {2'b00, idx, 2'b00};
        rready  <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr_ok(input logic [7:0] idx, input logic [7:0] d);
        logic [1:0] r;
        axi_wr(idx, d, 4'h1, r);
        chk_resp(r, RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(idx, d, r);
        chk_data(d, exp);
        chk_resp(r, RESP_OKAY);
    endtask

    task automatic t_reset();
        rd_chk(XBIAS_IDX, 32'h00);
        rd_chk(BATT_IDX, 32'h03);
        rd_chk(AUTO_IDX, 32'h00);
        rd_chk(STATUS_IDX, 32'h04);
        rd_chk(LCDEB_IDX, 32'h0a);
        chk_data(32'(ctrl), 32'(exp_ctrl(8'h00, 8'h03, 8'h00, 3'b000)));
    endtask

    // every writable bit except the line state select set then cleared; reserved bits must read zero
    task automatic t_rw();
        logic [7:0] idx [4] = '{XBIAS_IDX, BATT_IDX, AUTO_IDX, LCDEB_IDX};
        logic [7:0] msk [4] = '{8'h7f, 8'h19, 8'h77, 8'h7f};
        logic [1:0] r;
        foreach (idx[i]) begin
            wr_ok(idx[i], 8'hff);
            rd_chk(idx[i], {24'h0, msk[i]});
        end
        chk_data(32'(ctrl), 32'(exp_ctrl(8'h7f, 8'h19, 8'h77, 3'b000)));
        axi_wr(STATUS_IDX, 8'hff, 4'h1, r);
        chk_resp(r, RESP_OKAY);
        rd_chk(STATUS_IDX, 32'h04);
        foreach (idx[i]) begin
            wr_ok(idx[i], 8'h00);
        end
        chk_data(32'(ctrl), 32'(exp_ctrl(8'h00, 8'h00, 8'h00, 3'b000)));
    endtask

    // on-hook field applies only in the on-hook transmission states
    task automatic t_bias();
        wr_ok(XBIAS_IDX, 8'h1b);
        wr_ok(LINE_STATE_IDX, 8'h02);
        chk_data(32'(ctrl.bias_level), 32'h2);
        wr_ok(LINE_STATE_IDX, 8'h06);
        chk_data(32'(ctrl.bias_level), 32'h2);
        wr_ok(LINE_STATE_IDX, 8'h01);
        chk_data(32'(ctrl.bias_level), 32'h3);
    endtask

    task automatic t_bus();
        logic [31:0] d;
        logic [1:0]  r;
        axi_wr(8'h46, 8'h5a, 4'h1, r);
        chk_resp(r, RESP_SLVERR);
        axi_rd(8'h46, d, r);
        chk_data(d, 32'h0);
        chk_resp(r, RESP_SLVERR);
        axi_wr(XBIAS_IDX, 8'h7f, 4'h0, r);
        chk_resp(r, RESP_OKAY);
        rd_chk(XBIAS_IDX, 32'h1b);
    endtask

    task automatic t_loop();
        wr_ok(LCDEB_IDX, 8'h02);
        wr_ok(AUTO_IDX, 8'h02);
        wr_ok(LINE_STATE_IDX, 8'h02);
        det <= 1'b1;
        repeat (8) @(posedge clk);
        chk_data(32'(ctrl.line_state_shadow), 32'h2);
        repeat (20) @(posedge clk);
        chk_data(32'(ctrl.line_state_shadow), 32'h1);
        rd_chk(STATUS_IDX, 32'h01);
        det <= 1'b0;
        repeat (20) @(posedge clk);
        rd_chk(STATUS_IDX, 32'h04);
    endtask

    // ring trip debounce is ten ticks; first pass in manual mode
    task automatic t_ring();
        logic [31:0] d;
        logic [1:0]  r;
        wr_ok(AUTO_IDX, 8'h00);
        wr_ok(LINE_STATE_IDX, 8'h04);
        det <= 1'b1;
        repeat (20) @(posedge clk);
        rd_chk(STATUS_IDX, 32'h00);
        repeat (40) @(posedge clk);
        axi_rd(STATUS_IDX, d, r);
        chk_data(d & 32'h2, 32'h2);
        chk_data(32'(ctrl.line_state_shadow), 32'h4);
        det <= 1'b0;
        repeat (60) @(posedge clk);
        wr_ok(AUTO_IDX, 8'h04);
        det <= 1'b1;
        repeat (60) @(posedge clk);
        chk_data(32'(ctrl.line_state_shadow), 32'h1);
        det <= 1'b0;
        repeat (60) @(posedge clk);
    endtask

    task automatic t_alarm();
        wr_ok(AUTO_IDX, 8'h00);
        wr_ok(LINE_STATE_IDX, 8'h05);
        rd_chk(LINE_STATE_IDX, 32'h55);
        alarm <= 1'b1;
        repeat (3) @(posedge clk);
        chk_data(32'(ctrl.line_state_shadow), 32'h5);
        wr_ok(AUTO_IDX, 8'h01);
        chk_data(32'(ctrl.line_state_shadow), 32'h0);
        alarm <= 1'b0;
        rd_chk(LINE_STATE_IDX, 32'h05);
    endtask

    initial begin
        {clk, rstn, det, alarm, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_rw();
        t_bias();
        t_bus();
        t_loop();
        t_ring();
        t_alarm();
        print_verdict();
    end

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
